// File: core/sram_port_cfg.svh
`ifndef SRAM_PORT_CFG_SVH
`define SRAM_PORT_CFG_SVH

// Array shape
`define SRAM_ADDR_W 17
`define SRAM_DATA_W 8
`define SRAM_WORDS 131072

// Reference clock
`define CLK_PERIOD_NS 40

// Slowest speed grade figures, in ns
`define READ_ACCESS_NS 15
`define STROBE_OE_HIGH_NS 9
`define STROBE_OE_LOW_NS 15
`define SEL_TO_END_NS 9
`define ADDR_TO_END_NS 9
`define DATA_TO_END_NS 7

// Wait timer width
`define TIMER_W 4

`endif

// File: core/sram_port_pkg.sv
`include "sram_port_cfg.svh"

package sram_port_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_W_SETUP,
        ST_W_PULSE,
        ST_W_END,
        ST_R_WAIT,
        ST_R_END
    } port_state_t;

    typedef logic [`SRAM_ADDR_W-1:0] word_address_t;
    typedef logic [`SRAM_DATA_W-1:0] data_word_t;
    typedef logic [`TIMER_W-1:0] wait_count_t;

    typedef struct packed {
        port_state_t state;
        word_address_t word_address;
        data_word_t data_out;
        logic data_oe;
        logic select_n;
        logic write_strobe_n;
        logic out_enable_n;
        data_word_t rdata;
        logic rvalid;
        logic ready;
        logic timer_load;
        wait_count_t timer_count;
    } port_regs_t;

    typedef struct packed {
        wait_count_t remain;
    } timer_regs_t;

    // Least time in whole clock cycles, never below one
    function automatic int ns_to_cycles(input int ns, input int period_ns);
        int cyc;
        cyc = (ns + period_ns - 1) / period_ns;
        return (cyc < 1) ? 1 : cyc;
    endfunction

endpackage

// File: core/sram_timer_if.sv
`timescale 1ns/1ns
interface sram_timer_if;
    import sram_port_pkg::*;
    logic load;
    wait_count_t count;
    logic done;
    modport ctrl (output load, output count, input done);
    modport timer (input load, input count, output done);
endinterface

// File: core/sram_wait_timer.sv
`timescale 1ns/1ns
module sram_wait_timer (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    sram_timer_if.timer tmr
);
    import sram_port_pkg::*;

    timer_regs_t r;
    timer_regs_t next_r;

    // Reload on request, else count down to zero and rest there
    always_comb begin
        next_r = r;
        if (tmr.load) begin
            next_r.remain = tmr.count;
        end else if (r.remain != '0) begin
            next_r.remain = r.remain - wait_count_t'(1);
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign tmr.done = (r.remain == '0);
endmodule // sram_wait_timer

// File: core/async_static_ram_port.sv
`timescale 1ns/1ns
`include "sram_port_cfg.svh"
// How it works
// RULE_01: Device holds 131,072 bytes, 17-bit address.
// RULE_02: Device stores only while select and strobe low.
// RULE_03: Write starts at later falling edge.
// RULE_04: Write ends at first rising edge.
// RULE_05: Address stable before the write starts.
// RULE_06: Address unchanged until write has ended.
// RULE_07: Address valid long enough before write end.
// RULE_08: Select low long enough before write end.
// RULE_09: Strobe pulse minimum with outputs off.
// RULE_10: Longer strobe pulse when outputs stay on.
// RULE_11: Write data set up, held to end.
// RULE_12: Device floats data when strobe falls.
// RULE_13: Late select keeps device outputs off.
// RULE_14: Device drives again 3 ns after write.
// RULE_15: Device then shows data of current address.
// RULE_16: Strobe stays high through every read.
// RULE_17: Read data valid after select falls.
// RULE_18: Read data valid after output enable falls.
// RULE_19: Old data held briefly after address change.
// RULE_20: Device floats data when deselected.
// RULE_21: Device floats data when outputs disabled.
// RULE_22: Never drive data while device may drive.
// RULE_23: Count cycles covering every minimum time.
module async_static_ram_port #(
    parameter int READ_ACCESS_NS = `READ_ACCESS_NS,
    parameter int STROBE_NS = `STROBE_OE_LOW_NS
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_req,
    input wire logic i_write,
    input wire sram_port_pkg::word_address_t i_addr,
    input wire sram_port_pkg::data_word_t i_wdata,
    output logic o_ready,
    output sram_port_pkg::data_word_t o_rdata,
    output logic o_rvalid,
    output sram_port_pkg::word_address_t o_word_address,
    output logic o_select_n,
    output logic o_write_strobe_n,
    output logic o_out_enable_n,
    output sram_port_pkg::data_word_t o_data_out,
    output logic o_data_oe,
    input wire sram_port_pkg::data_word_t i_data_in
);
    import sram_port_pkg::*;

    // Cycle counts derived from the ns figures
    localparam int ACCESS_CYC = ns_to_cycles(READ_ACCESS_NS, `CLK_PERIOD_NS);
    localparam int STROBE_CYC = ns_to_cycles(STROBE_NS, `CLK_PERIOD_NS);
    localparam int SEL_CYC = ns_to_cycles(`SEL_TO_END_NS, `CLK_PERIOD_NS);
    localparam int ADDR_CYC = ns_to_cycles(`ADDR_TO_END_NS, `CLK_PERIOD_NS);
    localparam int DATA_CYC = ns_to_cycles(`DATA_TO_END_NS, `CLK_PERIOD_NS);
    localparam int MAX_WAIT = (1 << `TIMER_W);

    if (ACCESS_CYC > MAX_WAIT || STROBE_CYC > MAX_WAIT) begin : g_check
        $error("Wait times do not fit the wait timer");
    end
    if (`SRAM_WORDS != (1 << `SRAM_ADDR_W)) begin : g_shape
        $error("Address width does not match array depth");
    end

    port_regs_t r;
    port_regs_t next_r;
    sram_timer_if tmr ();

    sram_wait_timer u_timer (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .tmr(tmr)
    );

    assign tmr.load = r.timer_load;
    assign tmr.count = r.timer_count;

    always_comb begin
        next_r = r;
        next_r.timer_load = 1'h0;
        next_r.rvalid = 1'h0;
        unique case (r.state)
            ST_IDLE: begin
                if (i_req && r.ready) begin
                    next_r.ready = 1'h0;
                    next_r.word_address = i_addr; // RULE_05
                    next_r.select_n = 1'h0;
                    if (i_write) begin
                        next_r.out_enable_n = 1'h1; // RULE_09
                        next_r.data_out = i_wdata;
                        next_r.data_oe = 1'h1; // RULE_22
                        next_r.state = ST_W_SETUP;
                    end else begin
                        next_r.out_enable_n = 1'h0;
                        next_r.timer_load = 1'h1;
                        next_r.timer_count = wait_count_t'(ACCESS_CYC - 1); // RULE_23
                        next_r.state = ST_R_WAIT;
                    end
                end
            end
            ST_W_SETUP: begin
                next_r.write_strobe_n = 1'h0;
                next_r.timer_load = 1'h1;
                next_r.timer_count = wait_count_t'(STROBE_CYC - 1); // RULE_10
                next_r.state = ST_W_PULSE;
            end
            ST_W_PULSE: begin
                if (tmr.done && !r.timer_load) begin
                    next_r.write_strobe_n = 1'h1; // RULE_11
                    next_r.state = ST_W_END;
                end
            end
            ST_W_END: begin
                next_r.select_n = 1'h1; // RULE_06
                next_r.data_oe = 1'h0;
                next_r.ready = 1'h1;
                next_r.state = ST_IDLE;
            end
            ST_R_WAIT: begin
                if (tmr.done && !r.timer_load) begin
                    next_r.rdata = i_data_in; // RULE_23
                    next_r.rvalid = 1'h1;
                    next_r.select_n = 1'h1;
                    next_r.out_enable_n = 1'h1;
                    next_r.state = ST_R_END;
                end
            end
            ST_R_END: begin
                next_r.ready = 1'h1; // RULE_22
                next_r.state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            r <= '{state: ST_IDLE, word_address: '0, data_out: '0, data_oe: 1'h0,
                   select_n: 1'h1, write_strobe_n: 1'h1, out_enable_n: 1'h1,
                   rdata: '0, rvalid: 1'h0, ready: 1'h1, timer_load: 1'h0,
                   timer_count: '0};
        end else begin
            r <= next_r;
        end
    end

    assign o_ready = r.ready;
    assign o_rdata = r.rdata;
    assign o_rvalid = r.rvalid;
    assign o_word_address = r.word_address;
    assign o_select_n = r.select_n;
    assign o_write_strobe_n = r.write_strobe_n;
    assign o_out_enable_n = r.out_enable_n;
    assign o_data_out = r.data_out;
    assign o_data_oe = r.data_oe;

    // Helper ages for the timing checks
    int strobe_age;
    int sel_age;
    int addr_age;
    int data_age;
    int read_age;

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            strobe_age <= 0;
            sel_age <= 0;
            addr_age <= 0;
            data_age <= 0;
            read_age <= 0;
        end else begin
            strobe_age <= next_r.write_strobe_n ? 0 : strobe_age + 1;
            sel_age <= next_r.select_n ? 0 : sel_age + 1;
            addr_age <= (next_r.word_address != r.word_address) ? 0 : addr_age + 1;
            data_age <= (!next_r.data_oe || next_r.data_out != r.data_out) ? 0 : data_age + 1;
            read_age <= next_r.out_enable_n ? 0 : read_age + 1;
        end
    end

    AST_ADDR_SETUP: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RULE_05
        $fell(o_write_strobe_n) |-> $stable(o_word_address) && $past(!o_select_n))
        else $error("Address or select not settled at write start");

    AST_ADDR_HELD: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RULE_06
        !o_write_strobe_n |=> $stable(o_word_address))
        else $error("Address moved before write end");

    AST_ADDR_AGE: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RULE_07
        $rose(o_write_strobe_n) |-> addr_age >= ADDR_CYC)
        else $error("Address valid too briefly before write end");

    AST_SEL_AGE: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RULE_08
        $rose(o_write_strobe_n) |-> !o_select_n && sel_age >= SEL_CYC)
        else $error("Select low too briefly before write end");

    AST_STROBE_OE_HIGH: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RULE_09
        !o_write_strobe_n |-> o_out_enable_n)
        else $error("Output enable low during strobe");

    AST_STROBE_WIDTH: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RULE_10
        $rose(o_write_strobe_n) |-> $past(strobe_age) + 1 >= STROBE_CYC)
        else $error("Strobe pulse too short");

    AST_DATA_HELD: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RULE_11
        $rose(o_write_strobe_n) |-> o_data_oe && data_age >= DATA_CYC)
        else $error("Write data not held to write end");

    AST_READ_STROBE_HIGH: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RULE_16
        !o_out_enable_n |-> o_write_strobe_n && !o_data_oe)
        else $error("Strobe low or data driven during read");

    AST_NO_CONTENTION: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RULE_22
        $rose(o_data_oe) |-> o_out_enable_n && $past(o_out_enable_n))
        else $error("Data driven while device may drive");

    AST_READ_WAIT: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RULE_23
        o_rvalid |-> $past(read_age) + 1 >= ACCESS_CYC ##1 o_ready)
        else $error("Read sampled before access time");

    AST_STROBE_IN_SEL: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RULE_08
        !o_write_strobe_n |-> !o_select_n && o_data_oe)
        else $error("Strobe low outside select or driven data");

    AST_WRITE_RELEASE: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RULE_06
        $rose(o_write_strobe_n) |=> o_select_n && !o_data_oe && $stable(o_word_address))
        else $error("Pins not released cleanly after write end");
endmodule // async_static_ram_port

// File: verification/sram_device_model.sv
`timescale 1ns/1ns
module sram_device_model
    import sram_port_pkg::*;
#(
    parameter int ACCESS_NS = 15,
    parameter int FLOAT_NS = 3
) (
    input wire word_address_t i_word_address,
    input wire logic i_select_n,
    input wire logic i_write_strobe_n,
    input wire logic i_out_enable_n,
    input wire data_word_t i_bus,
    output data_word_t o_dev_data,
    output logic o_dev_oe
);
    data_word_t mem [word_address_t];
    logic writing;
    initial o_dev_data = 8'h00;
    assign writing = !i_select_n && !i_write_strobe_n;
    // Capture as the overlap ends
    always @(negedge writing) begin
        if (!$isunknown(i_word_address))
            mem[i_word_address] = i_bus;
    end
    // Drive only when selected, strobe high, outputs on
    assign #(FLOAT_NS) o_dev_oe = !i_select_n && i_write_strobe_n
        && !i_out_enable_n;
    // Old word briefly, then garbage, then the stored word
    always @(i_word_address or writing or i_select_n or i_out_enable_n) begin
        o_dev_data <= #(FLOAT_NS) ~o_dev_data;
        #0;
        o_dev_data <= #(ACCESS_NS) mem.exists(i_word_address) ?
            mem[i_word_address] : 8'h00;
    end
endmodule // sram_device_model

// File: verification/async_static_ram_port_tb.sv
`timescale 1ns/1ns
module async_static_ram_port_tb;
    import sram_port_pkg::*;
    logic i_ref_clk = 1'h0, i_rst = 1'h1, i_req = 1'h0, i_write = 1'h0;
    word_address_t i_addr = '0, o_word_address;
    data_word_t i_wdata = '0, o_rdata, o_data_out, bus, last = '0, dev_data;
    logic o_ready, o_rvalid, o_select_n, o_write_strobe_n, o_out_enable_n, o_data_oe, dev_oe;
    int n_errors = 0, n_compared = 0;
    // Undriven bus shows a pattern that changes each cycle
    assign bus = o_data_oe ? o_data_out : dev_oe ? dev_data : ~last;
    always @(posedge i_ref_clk) last <= bus;
    async_static_ram_port async_static_ram_port_inst (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
        .i_req(i_req), .i_write(i_write), .i_addr(i_addr), .i_wdata(i_wdata),
        .o_ready(o_ready), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
        .o_word_address(o_word_address), .o_select_n(o_select_n),
        .o_write_strobe_n(o_write_strobe_n), .o_out_enable_n(o_out_enable_n),
        .o_data_out(o_data_out), .o_data_oe(o_data_oe), .i_data_in(bus));
    sram_device_model sram_device_model_inst (.i_word_address(o_word_address),
        .i_select_n(o_select_n), .i_write_strobe_n(o_write_strobe_n),
        .i_out_enable_n(o_out_enable_n), .i_bus(bus), .o_dev_data(dev_data),
        .o_dev_oe(dev_oe));
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Raise a request, wait until o_ready is high at a falling edge, drop it two rising edges later
    task automatic issue(input logic w, input word_address_t a, input data_word_t d);
        int k;
        @(posedge i_ref_clk);
        i_req <= 1'h1;
        i_write <= w;
        i_addr <= a;
        i_wdata <= d;
        for (k = 0; k < 12; k++) begin
            @(negedge i_ref_clk);
            if (o_ready === 1'h1)
                break;
        end
        if (o_ready !== 1'h1) begin
            n_errors++;
            end_sim();
        end
        @(posedge i_ref_clk);
        @(posedge i_ref_clk);
        i_req <= 1'h0;
    endtask
    task automatic do_write(input word_address_t a, input data_word_t d);
        issue(1'h1, a, d);
        @(negedge i_ref_clk);
        chk("write address", o_word_address, a);
        chk("write data", o_data_out, d);
        chk("strobe", o_write_strobe_n, 1'h0);
    endtask
    task automatic do_read(input word_address_t a, input data_word_t exp);
        issue(1'h0, a, 8'h00);
        @(negedge i_ref_clk);
        chk("read pulse early", o_rvalid, 1'h0);
        @(negedge i_ref_clk);
        chk("read pulse", o_rvalid, 1'h1);
        chk("read data", o_rdata, exp);
        chk("strobe in read", o_write_strobe_n, 1'h1);
    endtask
    // Pin relations watched on every cycle
    always @(negedge i_ref_clk) begin
        if (o_write_strobe_n === 1'h0)
            chk("pins in write", {o_select_n, o_out_enable_n, o_data_oe}, 3'h3);
        if (o_data_oe === 1'h1)
            chk("bus clash", dev_oe, 1'h0);
    end
    task automatic t_reset();
        @(negedge i_ref_clk);
        chk("idle pins", {o_ready, o_select_n, o_write_strobe_n, o_out_enable_n,
            o_data_oe, o_rvalid}, 6'h3C);
        chk("idle read data", o_rdata, 32'h0000_0000);
        chk("idle address", o_word_address, 32'h0000_0000);
        chk("idle write data", o_data_out, 32'h0000_0000);
        $display("test reset done");
    endtask
    task automatic t_edges();
        word_address_t a [3] = '{17'h0_0000, 17'h1_FFFF, 17'h0_AAAA};
        data_word_t d [3] = '{8'h5A, 8'hA5, 8'hFF};
        for (int i = 0; i < 3; i++)
            do_write(a[i], d[i]);
        for (int i = 2; i >= 0; i--)
            do_read(a[i], d[i]);
        $display("test edges done");
    endtask
    task automatic t_back_to_back();
        do_write(17'h0_0010, 8'h11);
        do_write(17'h0_0011, 8'h22);
        do_read(17'h0_0011, 8'h22);
        do_read(17'h0_0010, 8'h11);
        do_read(17'h0_0011, 8'h22);
        $display("test back to back done");
    endtask
    task automatic t_refused();
        do_write(17'h0_0020, 8'h33);
        @(posedge i_ref_clk);
        i_req <= 1'h1;
        i_addr <= 17'h0_0010;
        i_wdata <= 8'hEE;
        @(posedge i_ref_clk);
        i_req <= 1'h0;
        do_read(17'h0_0010, 8'h11);
        do_read(17'h0_0020, 8'h33);
        $display("test refused done");
    endtask
    task automatic t_abort();
        issue(1'h0, 17'h0_0011, 8'h00);
        i_rst <= 1'h1;
        @(posedge i_ref_clk);
        @(posedge i_ref_clk);
        i_rst <= 1'h0;
        t_reset();
        do_read(17'h0_0020, 8'h33);
        $display("test abort done");
    endtask
    initial begin
        forever #20 i_ref_clk = ~i_ref_clk;
    end
    initial begin
        repeat (5) @(posedge i_ref_clk);
        i_rst <= 1'h0;
        t_reset();
        t_edges();
        t_back_to_back();
        t_refused();
        t_abort();
        repeat (4) @(posedge i_ref_clk);
        end_sim();
    end
endmodule // async_static_ram_port_tb
